// ### hdl/csr_cfg.svh
`ifndef CSR_CFG_SVH
`define CSR_CFG_SVH
// ****************************************
// Register offsets
// ****************************************
`define OFS_FW_REV 16'h1000
`define OFS_SLOT 16'h1002
`define OFS_CHAIN_ADDR 16'h1004
`define OFS_BIT_SET 16'h1006
`define OFS_BIT_CLR 16'h1008
`define OFS_IRQ_LEVEL 16'h100a
`define OFS_IRQ_VECTOR 16'h100c
`define OFS_STATUS 16'h100e
// ****************************************
// Reset values
// ****************************************
`define RST_FW_REV 16'h0000
`define RST_SLOT 5'h1f
`define RST_CHAIN_ADDR 8'haa
`define RST_IRQ_LEVEL 3'h0
`define RST_IRQ_VECTOR 8'h00
// ****************************************
// Control bit positions
// ****************************************
`define BIT_BERR 3
`define BIT_SEL_ADDR 4
`define BIT_SOFT_RST 7
// ****************************************
// Status bit positions
// ****************************************
`define ST_EVENT_AVAIL 0
`define ST_CHAIN_PEND 1
`define ST_BUSY 2
`define ST_GLOBAL_BUSY 3
`define ST_SLOT_MISSING 4
`define ST_PURGED 5
`define ST_TERM_ON 6
`define ST_TERM_OFF 7
`define ST_THRESHOLD 8
`endif

// ### hdl/csr_pkg.sv
package csr_pkg;
    // ****************************************
    // Access from the bus front end
    // ****************************************
    typedef struct packed {
        logic valid;
        logic write;
        logic [15:0] addr;
        logic [15:0] data;
    } bus_req_s;
    // ****************************************
    // Live state from the rest of the module
    // ****************************************
    typedef struct packed {
        logic event_available;
        logic conv_busy;
        logic buffer_full;
        logic mem_test;
        logic purged;
        logic bus_error_event;
        logic irq_requested;
        logic [4:0] trigger_count;
        logic [4:0] stored_events;
    } core_status_s;
endpackage

// ### hdl/vme_control_status_registers.sv
`timescale 1ns/1ps
`include "csr_cfg.svh"
// Functional notes
// - Revision location reads a fixed 16-bit value; writes ignored.
// - Slot position reloads from the backplane slot lines on every reset.
// - Five slot bits match configuration address bits A23 to A19.
// - Without slot lines the slot register is writable, default all ones.
// - With slot lines a slot write gets no acknowledge.
// - Written slot value takes effect only after a following reset.
// - Chain address register is read/write, resets to 0xaa.
// - Bit-set write sets ones, leaves zeros; read returns state.
// - Bit-clear write clears ones, leaves zeros; read returns state.
// - Bus-error flag bit 3 set by hardware or software, cleared by resets.
// - Address select bit 4: zero rotary switch, one decoder registers.
// - Soft reset bit holds reset until cleared via bit-clear.
// - Control bits other than bus-error clear only on hardware reset or bit-clear, not on soft reset.
// - Interrupt level is 3 bits, default zero, zero disables interrupts.
// - Vector byte is driven during interrupt acknowledge; default 0x00.
// - Status shows event available when buffer holds a complete event.
// - Global ready and busy are OR of chain lines.
// - Busy while converting, resetting, buffer full or memory test.
// - Missing-slot flag set when no slot lines exist.
// - Purged flag set once this board finished chained transfer.
// - Term-on flag when all on, term-off flag when all off.
// - Threshold flag when trigger count >= stored count with request and level.
module vme_control_status_registers #(
    parameter bit HAS_SLOT_LINES = 1'b1,
    parameter logic [15:0] FW_REVISION = `RST_FW_REV
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Register access
    input csr_pkg::bus_req_s bus_req,
    output logic bus_ack,
    output logic [15:0] bus_rdata,
    // Interrupt acknowledge
    input wire logic iack,
    output logic iack_valid,
    output logic [7:0] iack_vector,
    // Pins from the backplane and chain
    input wire logic [4:0] slot_number_lines,
    input wire logic chain_ready_line,
    input wire logic chain_busy_line,
    input wire logic all_term_on,
    input wire logic all_term_off,
    // Module internals
    input wire logic reset_pulse,
    input csr_pkg::core_status_s core,
    // Controls out
    output logic module_reset,
    output logic addr_from_decoder,
    output logic bus_error_flag,
    output logic [4:0] slot_position,
    output logic [7:0] chain_address,
    output logic [2:0] irq_level,
    output logic irq_enable,
    output logic busy_out,
    output logic [15:0] status_word
);
    import csr_pkg::*;

    // ****************************************
    // State
    // ****************************************
    typedef struct packed {
        logic [4:0] slot_s1;
        logic [4:0] slot_s2;
        logic [1:0] ready_s;
        logic [1:0] busy_s;
        logic [1:0] ton_s;
        logic [1:0] toff_s;
        logic load_pending;
        logic [4:0] slot_written;
        logic [4:0] slot;
        logic [7:0] chain_addr;
        logic berr;
        logic sel_addr;
        logic soft_rst;
        logic [2:0] level;
        logic [7:0] vector;
        logic ack;
        logic [15:0] rdata;
        logic iack_v;
        logic [7:0] iack_vec;
        logic mod_rst;
        logic busy;
        logic irq_en;
        logic [15:0] status;
    } state_s;

    state_s state_q;
    state_s state_d;

    logic wr;
    logic rd;
    logic [15:0] ctrl_word;
    logic any_soft_reset;
    logic [15:0] status_now;

    // ****************************************
    // Decoded strobes and combined words
    // ****************************************
    always_comb begin
        wr = bus_req.valid & bus_req.write;
        rd = bus_req.valid & ~bus_req.write;
        ctrl_word = 16'h0000;
        ctrl_word[`BIT_BERR] = state_q.berr;
        ctrl_word[`BIT_SEL_ADDR] = state_q.sel_addr;
        ctrl_word[`BIT_SOFT_RST] = state_q.soft_rst;
        // A held reset and a one-shot reset both count as soft resets
        any_soft_reset = state_q.soft_rst | reset_pulse;
    end

    always_comb begin
        status_now = 16'h0000;
        status_now[`ST_EVENT_AVAIL] = core.event_available;
        status_now[`ST_CHAIN_PEND] = state_q.ready_s[1];
        status_now[`ST_GLOBAL_BUSY] = state_q.busy_s[1];
        status_now[`ST_BUSY] = core.conv_busy
            | any_soft_reset
            | state_q.load_pending
            | core.buffer_full
            | core.mem_test;
        status_now[`ST_SLOT_MISSING] = ~HAS_SLOT_LINES;
        status_now[`ST_PURGED] = core.purged;
        status_now[`ST_TERM_ON] = state_q.ton_s[1];
        status_now[`ST_TERM_OFF] = state_q.toff_s[1];
        status_now[`ST_THRESHOLD] = (core.trigger_count >= core.stored_events)
            & core.irq_requested
            & (state_q.level != 3'h0);
    end

    // ****************************************
    // Next state
    // ****************************************
    always_comb begin
        state_d = state_q;

        // Pin synchronisers: first stage feeds only the second
        state_d.slot_s1 = slot_number_lines;
        state_d.slot_s2 = state_q.slot_s1;
        state_d.ready_s = {state_q.ready_s[0], chain_ready_line};
        state_d.busy_s = {state_q.busy_s[0], chain_busy_line};
        state_d.ton_s = {state_q.ton_s[0], all_term_on};
        state_d.toff_s = {state_q.toff_s[0], all_term_off};

        state_d.ack = 1'b0;
        state_d.rdata = 16'h0000;
        state_d.iack_v = 1'b0;

        // Slot position is taken on the first clean cycle after any reset,
        // so the synchronised lines have settled before they are trusted
        if (any_soft_reset) begin
            state_d.load_pending = 1'b1;
        end else if (state_q.load_pending) begin
            state_d.load_pending = 1'b0;
            if (HAS_SLOT_LINES) begin
                state_d.slot = state_q.slot_s2;
            end else begin
                state_d.slot = state_q.slot_written;
            end
        end

        if (wr) begin
            case (bus_req.addr)
                `OFS_FW_REV: begin
                    state_d.ack = 1'b1;
                end
                `OFS_SLOT: begin
                    // With slot lines the write is left unanswered
                    if (!HAS_SLOT_LINES) begin
                        state_d.slot_written = bus_req.data[4:0];
                        state_d.ack = 1'b1;
                    end
                end
                `OFS_CHAIN_ADDR: begin
                    state_d.chain_addr = bus_req.data[7:0];
                    state_d.ack = 1'b1;
                end
                `OFS_BIT_SET: begin
                    if (bus_req.data[`BIT_BERR]) begin
                        state_d.berr = 1'b1;
                    end
                    if (bus_req.data[`BIT_SEL_ADDR]) begin
                        state_d.sel_addr = 1'b1;
                    end
                    if (bus_req.data[`BIT_SOFT_RST]) begin
                        state_d.soft_rst = 1'b1;
                    end
                    state_d.ack = 1'b1;
                end
                `OFS_BIT_CLR: begin
                    if (bus_req.data[`BIT_BERR]) begin
                        state_d.berr = 1'b0;
                    end
                    if (bus_req.data[`BIT_SEL_ADDR]) begin
                        state_d.sel_addr = 1'b0;
                    end
                    if (bus_req.data[`BIT_SOFT_RST]) begin
                        state_d.soft_rst = 1'b0;
                    end
                    state_d.ack = 1'b1;
                end
                `OFS_IRQ_LEVEL: begin
                    state_d.level = bus_req.data[2:0];
                    state_d.ack = 1'b1;
                end
                `OFS_IRQ_VECTOR: begin
                    state_d.vector = bus_req.data[7:0];
                    state_d.ack = 1'b1;
                end
                `OFS_STATUS: begin
                    state_d.ack = 1'b1;
                end
                default: begin
                    // Unmapped offsets belong to other blocks
                    state_d.ack = 1'b0;
                end
            endcase
        end

        if (rd) begin
            state_d.ack = 1'b1;
            case (bus_req.addr)
                `OFS_FW_REV: begin
                    state_d.rdata = FW_REVISION;
                end
                `OFS_SLOT: begin
                    state_d.rdata = {11'h000, state_q.slot};
                end
                `OFS_CHAIN_ADDR: begin
                    state_d.rdata = {8'h00, state_q.chain_addr};
                end
                `OFS_BIT_SET: begin
                    state_d.rdata = ctrl_word;
                end
                `OFS_BIT_CLR: begin
                    state_d.rdata = ctrl_word;
                end
                `OFS_IRQ_LEVEL: begin
                    state_d.rdata = {13'h0000, state_q.level};
                end
                `OFS_IRQ_VECTOR: begin
                    state_d.rdata = {8'h00, state_q.vector};
                end
                `OFS_STATUS: begin
                    state_d.rdata = status_now;
                end
                default: begin
                    state_d.ack = 1'b0;
                end
            endcase
        end

        // Soft reset clears only the bus-error flag
        if (any_soft_reset) begin
            state_d.berr = 1'b0;
        end
        // A hardware bus error wins over a same-cycle soft-reset or bit-clear clear; a hardware reset still clears it
        if (core.bus_error_event) begin
            state_d.berr = 1'b1;
        end

        if (iack && state_q.level != 3'h0) begin
            state_d.iack_v = 1'b1;
            state_d.iack_vec = state_q.vector;
        end

        state_d.mod_rst = any_soft_reset | state_q.load_pending;
        state_d.busy = status_now[`ST_BUSY];
        state_d.irq_en = (state_d.level != 3'h0);
        state_d.status = status_now;
    end

    // ****************************************
    // Registers
    // ****************************************
    always_ff @(posedge clk) begin
        if (rst) begin
            // Synchronisers keep sampling through reset, so the reload
            // right after release already sees settled slot lines
            state_q.slot_s1 <= state_d.slot_s1;
            state_q.slot_s2 <= state_d.slot_s2;
            state_q.ready_s <= state_d.ready_s;
            state_q.busy_s <= state_d.busy_s;
            state_q.ton_s <= state_d.ton_s;
            state_q.toff_s <= state_d.toff_s;
            state_q.load_pending <= 1'b1;
            state_q.slot_written <= `RST_SLOT;
            state_q.slot <= `RST_SLOT;
            state_q.chain_addr <= `RST_CHAIN_ADDR;
            state_q.berr <= 1'b0;
            state_q.sel_addr <= 1'b0;
            state_q.soft_rst <= 1'b0;
            state_q.level <= `RST_IRQ_LEVEL;
            state_q.vector <= `RST_IRQ_VECTOR;
            state_q.ack <= 1'b0;
            state_q.rdata <= 16'h0000;
            state_q.iack_v <= 1'b0;
            state_q.iack_vec <= 8'h00;
            state_q.mod_rst <= 1'b1;
            state_q.busy <= 1'b1;
            state_q.irq_en <= 1'b0;
            state_q.status <= 16'h0000;
        end else begin
            state_q <= state_d;
        end
    end

    // ****************************************
    // Outputs, all straight from flip-flops
    // ****************************************
    assign bus_ack = state_q.ack;
    assign bus_rdata = state_q.rdata;
    assign iack_valid = state_q.iack_v;
    assign iack_vector = state_q.iack_vec;
    assign module_reset = state_q.mod_rst;
    assign addr_from_decoder = state_q.sel_addr;
    assign bus_error_flag = state_q.berr;
    assign slot_position = state_q.slot;
    assign chain_address = state_q.chain_addr;
    assign irq_level = state_q.level;
    // Level zero disables interrupt generation
    assign irq_enable = state_q.irq_en;
    assign busy_out = state_q.busy;
    assign status_word = state_q.status;

endmodule

// ### testbench/test_vme_control_status_registers.sv
`timescale 1ns/1ps
module test_vme_control_status_registers;
    import csr_pkg::*;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic iack = 1'b0;
    logic reset_pulse = 1'b0;
    logic [4:0] slot_number_lines = 5'h0b;
    logic chain_ready_line = 1'b0;
    logic chain_busy_line = 1'b0;
    logic all_term_on = 1'b0;
    logic all_term_off = 1'b0;
    core_status_s core = '0;
    bus_req_s bus_req;
    logic bus_ack, iack_valid, module_reset, addr_from_decoder, bus_error_flag, irq_enable, busy_out;
    logic [15:0] bus_rdata, status_word;
    logic [7:0] iack_vector, chain_address;
    logic [4:0] slot_position;
    logic [2:0] irq_level;
    // Second unit built without slot lines, sharing every pin but the bus
    bus_req_s bus_req_nl;
    logic bus_ack_nl;
    logic [15:0] bus_rdata_nl;
    logic [4:0] slot_position_nl;
    bit via_no_lines = 1'b0;
    // Arbitrary revision code
    localparam logic [15:0] FW_REV_TB = 16'h5a3c;
    int err_count = 0;
    int samples_checked = 0;
    always #50 clk = ~clk;
    vme_control_status_registers #(.FW_REVISION(FW_REV_TB)) i_vme_control_status_registers (.clk, .rst, .bus_req,
        .bus_ack,
        .bus_rdata, .iack, .iack_valid, .iack_vector, .slot_number_lines, .chain_ready_line,
        .chain_busy_line, .all_term_on, .all_term_off, .reset_pulse, .core, .module_reset,
        .addr_from_decoder, .bus_error_flag, .slot_position, .chain_address, .irq_level,
        .irq_enable, .busy_out, .status_word);
    vme_master_model i_vme_master_model (.clk, .bus_req, .bus_ack, .bus_rdata);
    vme_control_status_registers #(.HAS_SLOT_LINES(1'b0), .FW_REVISION(FW_REV_TB))
        i_vme_control_status_registers_nl (.clk, .rst, .bus_req(bus_req_nl), .bus_ack(bus_ack_nl),
        .bus_rdata(bus_rdata_nl), .iack, .iack_valid(), .iack_vector(), .slot_number_lines, .chain_ready_line,
        .chain_busy_line, .all_term_on, .all_term_off, .reset_pulse, .core, .module_reset(),
        .addr_from_decoder(), .bus_error_flag(), .slot_position(slot_position_nl), .chain_address(),
        .irq_level(), .irq_enable(), .busy_out(), .status_word());
    vme_master_model i_vme_master_model_nl (.clk, .bus_req(bus_req_nl), .bus_ack(bus_ack_nl),
        .bus_rdata(bus_rdata_nl));
    // ****
    // Helpers
    // ****
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        samples_checked++;
        if (got !== exp) begin
            err_count++;
            $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic cycles(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic xfer_any(input logic w, input logic [15:0] a, input logic [15:0] d,
        output logic [15:0] r, output bit ok);
        if (via_no_lines) begin
            i_vme_master_model_nl.xfer(w, a, d, r, ok);
        end else begin
            i_vme_master_model.xfer(w, a, d, r, ok);
        end
    endtask
    task automatic rd(input logic [15:0] a, input logic [15:0] exp);
        logic [15:0] r;
        bit ok;
        xfer_any(1'b0, a, 16'h0000, r, ok);
        chk(ok ? r : 16'hxxxx, exp);
    endtask
    task automatic wr(input logic [15:0] a, input logic [15:0] d, input bit e);
        logic [15:0] r;
        bit ok;
        xfer_any(1'b1, a, d, r, ok);
        chk({15'h0, ok}, {15'h0, e});
    endtask
    task automatic soft_pulse();
        reset_pulse = 1'b1;
        cycles(1);
        reset_pulse = 1'b0;
        cycles(8);
    endtask
    task automatic tally_and_finish();
        if (err_count == 0 && samples_checked > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    // ****
    // Scenarios
    // ****
    task automatic t_defaults();
        rd(16'h1000, FW_REV_TB);
        rd(16'h1002, 16'h000b);
        chk({11'h000, slot_position}, 16'h000b);
        rd(16'h1004, 16'h00aa);
        rd(16'h1006, 16'h0000);
        rd(16'h100a, 16'h0000);
        rd(16'h100c, 16'h0000);
    endtask
    task automatic t_slot();
        wr(16'h1002, 16'h0003, 1'b0);
        wr(16'h1010, 16'h0001, 1'b0);
        slot_number_lines = 5'h15;
        cycles(4);
        rd(16'h1002, 16'h000b);
        soft_pulse();
        rd(16'h1002, 16'h0015);
        // Unit without slot lines: writable register, applied on reset
        via_no_lines = 1'b1;
        rd(16'h1002, 16'h001f);
        rd(16'h100e, 16'h0010);
        wr(16'h1002, 16'h0009, 1'b1);
        rd(16'h1002, 16'h001f);
        soft_pulse();
        rd(16'h1002, 16'h0009);
        chk({11'h000, slot_position_nl}, 16'h0009);
        via_no_lines = 1'b0;
    endtask
    task automatic t_rw();
        wr(16'h1004, 16'h1234, 1'b1);
        rd(16'h1004, 16'h0034);
        chk({8'h00, chain_address}, 16'h0034);
        wr(16'h100a, 16'h000f, 1'b1);
        rd(16'h100a, 16'h0007);
        wr(16'h100c, 16'h12ab, 1'b1);
        rd(16'h100c, 16'h00ab);
        wr(16'h1000, 16'hffff, 1'b1);
        rd(16'h1000, FW_REV_TB);
    endtask
    task automatic t_set_clear();
        wr(16'h1006, 16'h0018, 1'b1);
        rd(16'h1006, 16'h0018);
        rd(16'h1008, 16'h0018);
        wr(16'h1008, 16'h0008, 1'b1);
        rd(16'h1006, 16'h0010);
        wr(16'h1006, 16'h0008, 1'b1);
        chk({15'h0, bus_error_flag}, 16'h0001);
        soft_pulse();
        rd(16'h1006, 16'h0010);
        core.bus_error_event = 1'b1;
        cycles(1);
        core.bus_error_event = 1'b0;
        rd(16'h1006, 16'h0018);
    endtask
    task automatic t_held();
        wr(16'h1006, 16'h0080, 1'b1);
        cycles(10);
        chk({15'h0, module_reset}, 16'h0001);
        chk({15'h0, busy_out}, 16'h0001);
        rd(16'h1006, 16'h0090);
        wr(16'h1008, 16'h0080, 1'b1);
        cycles(6);
        chk({15'h0, module_reset}, 16'h0000);
        chk({15'h0, busy_out}, 16'h0000);
        wr(16'h1008, 16'h0010, 1'b1);
        chk({15'h0, addr_from_decoder}, 16'h0000);
    endtask
    task automatic t_iack();
        wr(16'h100a, 16'h0000, 1'b1);
        chk({15'h0, irq_enable}, 16'h0000);
        iack = 1'b1;
        cycles(1);
        iack = 1'b0;
        chk({15'h0, iack_valid}, 16'h0000);
        wr(16'h100a, 16'h0003, 1'b1);
        chk({15'h0, irq_enable}, 16'h0001);
        wr(16'h100c, 16'h12a5, 1'b1);
        iack = 1'b1;
        cycles(1);
        iack = 1'b0;
        chk({7'h0, iack_valid, iack_vector}, 16'h01a5);
    endtask
    task automatic t_status();
        core = {1'b1, 1'b0, 1'b1, 1'b0, 1'b1, 1'b0, 1'b1, 5'h05, 5'h05};
        chain_ready_line = 1'b1;
        all_term_on = 1'b1;
        cycles(6);
        rd(16'h100e, 16'h0167);
        chk(status_word, 16'h0167);
        chk({15'h0, busy_out}, 16'h0001);
        core.stored_events = 5'h06;
        chain_busy_line = 1'b1;
        all_term_on = 1'b0;
        all_term_off = 1'b1;
        cycles(6);
        rd(16'h100e, 16'h00af);
    endtask
    initial begin
        cycles(20);
        rst = 1'b0;
        t_defaults();
        t_slot();
        t_rw();
        t_set_clear();
        t_held();
        t_iack();
        t_status();
        tally_and_finish();
    end
    // Whole run needs well under 1000 cycles
    initial begin
        #500000;
        err_count++;
        tally_and_finish();
    end
endmodule

// ### testbench/vme_csr_chk.sv
`timescale 1ns/1ps
module vme_csr_chk
    import csr_pkg::*;
#(
    parameter bit HAS_SLOT_LINES = 1'b1,
    parameter logic [15:0] FW_REVISION = 16'h0000
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Register access
    input csr_pkg::bus_req_s bus_req,
    input wire logic bus_ack,
    input wire logic [15:0] bus_rdata,
    // Interrupt acknowledge
    input wire logic iack,
    input wire logic iack_valid,
    // Controls and status
    input wire logic [2:0] irq_level,
    input wire logic addr_from_decoder,
    input wire logic module_reset,
    input wire logic busy_out,
    input wire logic [7:0] chain_address,
    input wire logic [15:0] status_word
);
    // ****
    // Checks
    // ****
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    chk_fw_fixed: assert property (bus_req.valid && !bus_req.write && bus_req.addr == 16'h1000 |=>
        bus_ack && bus_rdata == FW_REVISION) else $error("revision word wrong");
    chk_slot_refused: assert property (HAS_SLOT_LINES && bus_req.valid && bus_req.write
        && bus_req.addr == 16'h1002 |=> !bus_ack) else $error("slot write acknowledged");
    chk_unmapped_quiet: assert property (bus_req.valid && bus_req.addr == 16'h1010 |=> !bus_ack)
        else $error("unmapped access acknowledged");
    chk_reset_state: assert property ($fell(rst) |-> chain_address == 8'haa && busy_out)
        else $error("state after reset wrong");
    chk_level_off: assert property (iack && irq_level == 3'h0 |=> !iack_valid)
        else $error("acknowledge answered at level zero");
    chk_vector_answer: assert property (iack && irq_level != 3'h0 |=> iack_valid)
        else $error("acknowledge not answered");
    chk_set_select: assert property (bus_req.valid && bus_req.write && bus_req.addr == 16'h1006
        && bus_req.data[4] |=> addr_from_decoder) else $error("select bit not set");
    chk_clear_select: assert property (bus_req.valid && bus_req.write && bus_req.addr == 16'h1008
        && bus_req.data[4] |=> !addr_from_decoder) else $error("select bit not cleared");
    chk_status_spare: assert property (status_word[15:9] == 7'h00)
        else $error("spare status bits set");
    cover property (bus_ack);
    cover property (iack_valid);
    cover property ($fell(module_reset));
endmodule
bind vme_control_status_registers vme_csr_chk #(.HAS_SLOT_LINES(HAS_SLOT_LINES), .FW_REVISION(FW_REVISION))
    i_vme_csr_chk (.clk, .rst, .bus_req, .bus_ack, .bus_rdata, .iack, .iack_valid, .irq_level,
    .addr_from_decoder, .module_reset, .busy_out, .chain_address, .status_word);

// ### testbench/vme_master_model.sv
`timescale 1ns/1ps
module vme_master_model (
    // Clock
    input wire logic clk,
    // Register access
    output csr_pkg::bus_req_s bus_req,
    input wire logic bus_ack,
    input wire logic [15:0] bus_rdata
);
    import csr_pkg::*;
    initial bus_req = '0;
    // One word per access; a missing answer is waited out, never retried
    task automatic xfer(input logic w, input logic [15:0] a, input logic [15:0] d,
        output logic [15:0] r, output bit ok);
        int n;
        @(posedge clk);
        #1;
        bus_req = '{valid: 1'b1, write: w, addr: a, data: d};
        ok = 1'b0;
        r = 'x;
        for (n = 0; n < 4 && !ok; n++) begin
            @(posedge clk);
            #1;
            bus_req.valid = 1'b0;
            // Released lines must not keep showing the last value
            bus_req.addr = ~a;
            bus_req.data = ~d;
            if (bus_ack === 1'b1) begin
                ok = 1'b1;
                r = bus_rdata;
            end
        end
    endtask
endmodule
